// file: rtl/pmw_defs.svh
`ifndef PMW_DEFS_SVH
`define PMW_DEFS_SVH
`define PMW_GPIO_W 25
`define PMW_CNT_W 32
`define PMW_CLK_HZ 10000000
`define PMW_CAL_S 8
`define PMW_CAL_CYCLES (`PMW_CAL_S * `PMW_CLK_HZ)
`define PMW_BOOT_CYCLES 16
`define PMW_IN_IDLE 30'h0200_0000
`endif

// file: rtl/pmw_pkg.sv
package pmw_pkg;
  typedef enum logic [6:0] {
    PMW_BOOT = 7'h01,
    PMW_ACTIVE = 7'h02,
    PMW_STANDBY = 7'h04,
    PMW_SLEEP = 7'h08,
    PMW_SAVE = 7'h10,
    PMW_DETACH = 7'h20,
    PMW_OFF = 7'h40
  } pmw_state_type;
endpackage

// file: rtl/pmw_power_mode_wake_controller.sv
`include "pmw_defs.svh"
module pmw_power_mode_wake_controller #(
  parameter logic [31:0] CAL_CYCLES = `PMW_CAL_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic supplyValid,
  input wire logic brownOut,
  input wire logic extResetN,
  input wire logic [`PMW_GPIO_W-1:0] gpioIn,
  input wire logic [`PMW_GPIO_W-1:0] gpioWakeEn,
  input wire logic gpioLatchEn,
  input wire logic [4:0] sleepCtrlPin,
  input wire logic sleepCtrlEn,
  input wire logic lpCompIn,
  input wire logic lpCompWakeEn,
  input wire logic nfcField,
  input wire logic radioWake,
  input wire logic sensorWake,
  input wire logic standbyReq,
  input wire logic sleepReq,
  input wire logic soft_poweroff_command,
  input wire logic dataSetReady,
  input wire logic stockFirmware,
  input wire logic saveDone,
  input wire logic detachDone,
  input wire logic rcClockSel,
  input wire logic highLoad,
  input wire logic linearOnly,
  input wire logic [`PMW_CNT_W-1:0] counterPeriod,
  input wire logic counterEn,
  output pmw_pkg::pmw_state_type powerState,
  output logic systemReset,
  output logic saveReq,
  output logic detachReq,
  output logic ramRetain,
  output logic lowClockReq,
  output logic rcCalStart,
  output logic buckEn,
  output logic counterEvent,
  output logic [`PMW_GPIO_W-1:0] gpioLatched,
  output logic nfcTagOnly
);
  import pmw_pkg::*;

  localparam int NIN = `PMW_GPIO_W + 5;
  localparam logic [NIN-1:0] IN_IDLE = `PMW_IN_IDLE;
  logic [NIN-1:0] rawIn;
  logic [NIN-1:0] syncA;
  logic [NIN-1:0] syncB;
  logic [NIN-1:0] syncC;
  logic [NIN-1:0] stable;
  logic [`PMW_GPIO_W-1:0] gpioS;
  logic extRstS;
  logic compS;
  logic nfcS;
  logic dsrS;
  logic dsrPrev;
  logic compPrev;
  logic supplyS;
  logic supplyPrev;
  logic ctrlPin;
  logic ctrlPrev;
  logic gpioWake;
  logic sleepWake;
  logic standbyWake;
  logic [`PMW_CNT_W-1:0] cnt;
  logic [31:0] calCnt;
  logic [4:0] bootCnt;
  logic fromSleep;
  logic next_saveForOff;
  logic offAfterSave;
  pmw_state_type next_state;
  logic [31:0] calGap;

  assign rawIn = {supplyValid, dataSetReady, nfcField, lpCompIn, extResetN, gpioIn};

  // Three-stage synchroniser, change accepted when stages two and three agree
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      // Idle pin levels, so no false edge follows reset
      syncA <= IN_IDLE;
      syncB <= IN_IDLE;
      syncC <= IN_IDLE;
      stable <= IN_IDLE;
    end else begin
      syncA <= rawIn;
      syncB <= syncA;
      syncC <= syncB;
      for (int i = 0; i < NIN; i++) begin
        if (syncB[i] == syncC[i]) begin
          stable[i] <= syncC[i];
        end
      end
    end
  end

  assign gpioS = stable[`PMW_GPIO_W-1:0];
  assign extRstS = stable[`PMW_GPIO_W];
  assign compS = stable[`PMW_GPIO_W+1];
  assign nfcS = stable[`PMW_GPIO_W+2];
  assign dsrS = stable[`PMW_GPIO_W+3];
  assign supplyS = stable[`PMW_GPIO_W+4];
  assign ctrlPin = (sleepCtrlPin < 5'(`PMW_GPIO_W)) ? gpioS[sleepCtrlPin] : 1'b0;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dsrPrev <= 1'b0;
      compPrev <= 1'b0;
      supplyPrev <= 1'b0;
      ctrlPrev <= 1'b0;
    end else begin
      dsrPrev <= dsrS;
      compPrev <= compS;
      supplyPrev <= supplyS;
      ctrlPrev <= ctrlPin;
    end
  end

  // Frozen in sleep only with latching on, else follows the pins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gpioLatched <= '0;
    end else if (powerState != PMW_SLEEP || !gpioLatchEn) begin
      gpioLatched <= gpioS;
    end
  end

  // Against entry levels when latched, else against last cycle
  assign gpioWake = |((gpioS ^ gpioLatched) & gpioWakeEn);
  assign sleepWake = gpioWake || (lpCompWakeEn && compS && !compPrev) || nfcS
                     || (sleepCtrlEn && ctrlPin != ctrlPrev)
                     || (stockFirmware && dsrS && !dsrPrev);
  assign standbyWake = sleepWake || counterEvent || (lpCompWakeEn && compS && !compPrev)
                       || radioWake || sensorWake;

  always_comb begin
    next_state = powerState;
    next_saveForOff = offAfterSave;
    case (powerState)
      PMW_BOOT: begin
        if (bootCnt == 5'(`PMW_BOOT_CYCLES)) begin
          next_state = PMW_ACTIVE;
        end
      end
      PMW_ACTIVE: begin
        if (soft_poweroff_command) begin
          next_state = PMW_SAVE;
          next_saveForOff = 1'b0;
        end else if (stockFirmware && !dsrS && dsrPrev) begin
          next_state = PMW_SAVE;
          next_saveForOff = 1'b1;
        end else if (sleepReq || (sleepCtrlEn && ctrlPin != ctrlPrev)) begin
          next_state = PMW_SLEEP;
        end else if (standbyReq) begin
          next_state = PMW_STANDBY;
        end
      end
      PMW_STANDBY: begin
        if (standbyWake) begin
          next_state = PMW_ACTIVE;
        end
      end
      PMW_SLEEP: begin
        if (sleepWake) begin
          next_state = PMW_BOOT;
        end
      end
      PMW_SAVE: begin
        if (saveDone) begin
          next_state = PMW_DETACH;
        end
      end
      PMW_DETACH: begin
        if (detachDone) begin
          next_state = offAfterSave ? PMW_SLEEP : PMW_BOOT;
        end
      end
      PMW_OFF: begin
        if (supplyS && !supplyPrev) begin
          next_state = PMW_BOOT;
        end
      end
      default: begin
        next_state = PMW_BOOT;
      end
    endcase
    // Brown-out and hardware reset preempt everything, no save
    if (brownOut || !supplyS) begin
      next_state = PMW_OFF;
    end else if (!extRstS) begin
      next_state = PMW_BOOT;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      powerState <= PMW_OFF;
      offAfterSave <= 1'b0;
      fromSleep <= 1'b0;
    end else begin
      powerState <= next_state;
      offAfterSave <= next_saveForOff;
      if (powerState == PMW_SLEEP && next_state == PMW_BOOT) begin
        fromSleep <= 1'b1;
      end else if (next_state == PMW_ACTIVE || next_state == PMW_OFF) begin
        fromSleep <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bootCnt <= '0;
    end else if (powerState == PMW_BOOT && next_state == PMW_BOOT && extRstS) begin
      bootCnt <= bootCnt + 5'd1;
    end else begin
      bootCnt <= '0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      systemReset <= 1'b1;
      saveReq <= 1'b0;
      detachReq <= 1'b0;
      ramRetain <= 1'b0;
      lowClockReq <= 1'b0;
      nfcTagOnly <= 1'b1;
    end else begin
      systemReset <= (next_state == PMW_BOOT) || (next_state == PMW_OFF);
      saveReq <= next_state == PMW_SAVE;
      detachReq <= next_state == PMW_DETACH;
      ramRetain <= (next_state == PMW_STANDBY) || (next_state == PMW_SLEEP)
                   || (next_state == PMW_BOOT && (fromSleep || powerState == PMW_SLEEP));
      lowClockReq <= next_state == PMW_STANDBY;
      nfcTagOnly <= 1'b1;
    end
  end

  // Regulator selection
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      buckEn <= 1'b0;
    end else begin
      buckEn <= !linearOnly && highLoad && powerState == PMW_ACTIVE;
    end
  end

  // Low-power counter, runs in active and standby
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      counterEvent <= 1'b0;
    end else if (counterEn && (powerState == PMW_ACTIVE || powerState == PMW_STANDBY)) begin
      counterEvent <= 1'b0;
      if (cnt >= counterPeriod) begin
        cnt <= '0;
        counterEvent <= 1'b1;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end else begin
      cnt <= '0;
      counterEvent <= 1'b0;
    end
  end

  // RC oscillator recalibration
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      calCnt <= '0;
      rcCalStart <= 1'b0;
    end else if (rcClockSel && powerState != PMW_OFF && powerState != PMW_SLEEP) begin
      rcCalStart <= 1'b0;
      if (calCnt >= CAL_CYCLES - 32'd1) begin
        calCnt <= '0;
        rcCalStart <= 1'b1;
      end else begin
        calCnt <= calCnt + 32'd1;
      end
    end else begin
      calCnt <= '0;
      rcCalStart <= 1'b0;
    end
  end

  // Cycles since the last recalibration, for the interval check
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      calGap <= '0;
    end else if (!rcClockSel || powerState == PMW_OFF || powerState == PMW_SLEEP || rcCalStart) begin
      calGap <= '0;
    end else begin
      calGap <= calGap + 32'd1;
    end
  end

  a_brownout_off: assert property (@(posedge core_clk) disable iff (!resetn)
    brownOut |=> powerState == PMW_OFF) else $error("brown-out did not shut down");
  a_sleep_reboot: assert property (@(posedge core_clk) disable iff (!resetn)
    (powerState == PMW_SLEEP && next_state == PMW_BOOT) |=> systemReset && ramRetain)
    else $error("sleep wake did not reboot");
  a_linear_only: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(linearOnly) |-> !buckEn) else $error("buck used in linear-only");
  a_cal_period: assert property (@(posedge core_clk) disable iff (!resetn)
    calCnt <= CAL_CYCLES) else $error("calibration interval exceeded");
  a_cal_gap: assert property (@(posedge core_clk) disable iff (!resetn)
    calGap <= CAL_CYCLES) else $error("recalibration gap too long");
  a_standby_clock: assert property (@(posedge core_clk) disable iff (!resetn)
    powerState == PMW_STANDBY |-> lowClockReq) else $error("no low clock in standby");
  a_standby_ram: assert property (@(posedge core_clk) disable iff (!resetn)
    powerState == PMW_STANDBY |-> ramRetain) else $error("RAM not kept in standby");
  a_soft_save: assert property (@(posedge core_clk) disable iff (!resetn)
    (powerState == PMW_ACTIVE && soft_poweroff_command && !brownOut && supplyS && extRstS)
    |=> saveReq) else $error("power-off did not save");
  a_reset_pin: assert property (@(posedge core_clk) disable iff (!resetn)
    (!extRstS && !brownOut && supplyS) |=> systemReset && !saveReq)
    else $error("reset pin ignored");
  a_counter_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    counterEvent |-> $past(powerState) inside {PMW_ACTIVE, PMW_STANDBY})
    else $error("counter event out of state");
  a_counter_wake: assert property (@(posedge core_clk) disable iff (!resetn)
    (powerState == PMW_STANDBY && counterEvent && !brownOut && supplyS && extRstS)
    |=> powerState == PMW_ACTIVE) else $error("counter event did not end standby");
  a_supply_boot: assert property (@(posedge core_clk) disable iff (!resetn)
    (powerState == PMW_OFF && supplyS && !supplyPrev && !brownOut)
    |=> powerState == PMW_BOOT && systemReset) else $error("supply rise did not reboot");
  a_sleep_nfc: assert property (@(posedge core_clk) disable iff (!resetn)
    (powerState == PMW_SLEEP && nfcS && !brownOut && supplyS && extRstS)
    |=> powerState == PMW_BOOT) else $error("carrier did not wake from sleep");
  a_sleep_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    (powerState == PMW_SLEEP && !sleepWake && !brownOut && supplyS && extRstS)
    |=> powerState == PMW_SLEEP) else $error("sleep left without a wake event");
  a_ctrl_sleep: assert property (@(posedge core_clk) disable iff (!resetn)
    (powerState == PMW_ACTIVE && sleepCtrlEn && ctrlPin != ctrlPrev && !soft_poweroff_command
     && !(stockFirmware && !dsrS && dsrPrev) && !brownOut && supplyS && extRstS)
    |=> powerState == PMW_SLEEP) else $error("control pin did not enter sleep");
  a_gpio_latch: assert property (@(posedge core_clk) disable iff (!resetn)
    (powerState == PMW_SLEEP && gpioLatchEn) |=> $stable(gpioLatched))
    else $error("latched levels changed in sleep");
  a_dsr_sleep: assert property (@(posedge core_clk) disable iff (!resetn)
    (powerState == PMW_DETACH && detachDone && offAfterSave && !brownOut && supplyS && extRstS)
    |=> powerState == PMW_SLEEP) else $error("line drop did not end in sleep");
endmodule

// file: tb/pmw_host_model.sv
module pmw_host_model (
  input wire logic pwrOn,
  input wire logic rstHold,
  output logic supplyValid,
  output logic extResetN
);
  timeunit 1ns;
  timeprecision 1ns;
  assign supplyValid = pwrOn;
  assign extResetN = rstHold ? 1'b0 : 1'b1;
endmodule

// file: tb/pmw_power_mode_wake_controller_tb.sv
`include "pmw_defs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin n_fail++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module pmw_power_mode_wake_controller_tb;
  import pmw_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, resetn = 0, pwrOn = 0, rstHold = 0, brownOut = 0;
  logic supplyValid, extResetN;
  logic [`PMW_GPIO_W-1:0] gpioIn = '0, gpioWakeEn = 25'h000_0001;
  logic gpioLatchEn = 1, lpCompIn = 0, lpCompWakeEn = 1, nfcField = 0;
  logic radioWake = 0, sensorWake = 0, standbyReq = 0, sleepReq = 0, softOff = 0;
  logic [4:0] sleepCtrlPin = 5'h03;
  logic sleepCtrlEn = 0, dataSetReady = 0, stockFirmware = 0;
  logic saveDone = 0, detachDone = 0, rcClockSel = 1, highLoad = 0, linearOnly = 0, counterEn = 0;
  pmw_state_type powerState;
  logic systemReset, saveReq, detachReq, ramRetain, lowClockReq, rcCalStart, buckEn, counterEvent, nfcTagOnly;
  logic [`PMW_GPIO_W-1:0] gpioLatched;
  int n_fail = 0, cmp_count = 0;
  always #50 core_clk = ~core_clk;
  pmw_host_model u_pmw_host_model (.pwrOn(pwrOn), .rstHold(rstHold), .supplyValid(supplyValid),
    .extResetN(extResetN));
  pmw_power_mode_wake_controller #(.CAL_CYCLES(32'h0000_0064)) u_pmw_power_mode_wake_controller (
    .core_clk(core_clk), .resetn(resetn), .supplyValid(supplyValid), .brownOut(brownOut),
    .extResetN(extResetN), .gpioIn(gpioIn), .gpioWakeEn(gpioWakeEn), .gpioLatchEn(gpioLatchEn),
    .sleepCtrlPin(sleepCtrlPin), .sleepCtrlEn(sleepCtrlEn), .lpCompIn(lpCompIn), .lpCompWakeEn(lpCompWakeEn),
    .nfcField(nfcField), .radioWake(radioWake), .sensorWake(sensorWake), .standbyReq(standbyReq),
    .sleepReq(sleepReq), .soft_poweroff_command(softOff), .dataSetReady(dataSetReady),
    .stockFirmware(stockFirmware),
    .saveDone(saveDone), .detachDone(detachDone), .rcClockSel(rcClockSel), .highLoad(highLoad),
    .linearOnly(linearOnly), .counterPeriod(32'h0000_0014), .counterEn(counterEn),
    .powerState(powerState), .systemReset(systemReset), .saveReq(saveReq), .detachReq(detachReq),
    .ramRetain(ramRetain), .lowClockReq(lowClockReq), .rcCalStart(rcCalStart), .buckEn(buckEn),
    .counterEvent(counterEvent), .gpioLatched(gpioLatched), .nfcTagOnly(nfcTagOnly));
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic expect_st(input string nm, input pmw_state_type s, input int n);
    for (int i = 0; i < n && powerState !== s; i++) @(negedge core_clk);
    `CHK(nm, s, powerState)
  endtask
  task automatic t_boot();
    pwrOn = 1;
    expect_st("boot", PMW_BOOT, 8);
    `CHK("sysRst", 1'b1, systemReset)
    cyc(16);
    `CHK("bootLen", PMW_BOOT, powerState)
    cyc(1);
    `CHK("active", PMW_ACTIVE, powerState)
    $display("test boot done");
  endtask
  task automatic t_softoff();
    softOff = 1;
    expect_st("save", PMW_SAVE, 3);
    softOff = 0;
    `CHK("saveReq", 1'b1, saveReq)
    cyc(5);
    `CHK("holdSave", PMW_SAVE, powerState)
    saveDone = 1;
    expect_st("detach", PMW_DETACH, 3);
    saveDone = 0;
    `CHK("detReq", 1'b1, detachReq)
    detachDone = 1;
    expect_st("reboot", PMW_BOOT, 3);
    detachDone = 0;
    expect_st("back", PMW_ACTIVE, 25);
    $display("test softoff done");
  endtask
  task automatic t_standby(input int src);
    standbyReq = 1;
    expect_st("stby", PMW_STANDBY, 3);
    standbyReq = 0;
    `CHK("lowClk", 1'b1, lowClockReq)
    `CHK("ramKeep", 1'b1, ramRetain)
    cyc(3);
    case (src)
      0: radioWake = 1;
      1: sensorWake = 1;
      default: counterEn = 1;
    endcase
    expect_st("stbyWake", PMW_ACTIVE, 40);
    {radioWake, sensorWake, counterEn} = 3'h0;
    $display("test standby %0d done", src);
  endtask
  task automatic t_sleep(input int src);
    gpioIn = 25'h0AA_0000;
    cyc(6);
    sleepReq = 1;
    expect_st("sleep", PMW_SLEEP, 3);
    sleepReq = 0;
    cyc(2);
    `CHK("latch", 25'h0AA_0000, gpioLatched)
    gpioIn[1] = 1;
    cyc(10);
    `CHK("maskPin", PMW_SLEEP, powerState)
    `CHK("latchHold", 25'h0AA_0000, gpioLatched)
    case (src)
      0: gpioIn[0] = 1;
      1: lpCompIn = 1;
      default: nfcField = 1;
    endcase
    expect_st("wakeBoot", PMW_BOOT, 8);
    {lpCompIn, nfcField} = 2'h0;
    gpioIn = '0;
    expect_st("wakeAct", PMW_ACTIVE, 25);
    $display("test sleep %0d done", src);
  endtask
  task automatic t_ctrl_dsr();
    sleepCtrlEn = 1;
    gpioIn[3] = 1;
    expect_st("ctrlSleep", PMW_SLEEP, 8);
    gpioIn[3] = 0;
    expect_st("ctrlWake", PMW_BOOT, 8);
    expect_st("ctrlAct", PMW_ACTIVE, 25);
    sleepCtrlEn = 0;
    stockFirmware = 1;
    dataSetReady = 1;
    cyc(6);
    `CHK("dsrHigh", PMW_ACTIVE, powerState)
    dataSetReady = 0;
    expect_st("dsrSave", PMW_SAVE, 8);
    saveDone = 1;
    expect_st("dsrDet", PMW_DETACH, 3);
    saveDone = 0;
    detachDone = 1;
    expect_st("dsrSleep", PMW_SLEEP, 3);
    detachDone = 0;
    gpioLatchEn = 0;
    gpioIn[5] = 1;
    cyc(6);
    `CHK("latchOff", 1'b1, gpioLatched[5])
    gpioIn[5] = 0;
    cyc(6);
    gpioLatchEn = 1;
    `CHK("dsrStay", PMW_SLEEP, powerState)
    dataSetReady = 1;
    expect_st("dsrWake", PMW_BOOT, 8);
    stockFirmware = 0;
    dataSetReady = 0;
    expect_st("dsrAct", PMW_ACTIVE, 25);
    $display("test ctrl dsr done");
  endtask
  task automatic t_reset_misc();
    int n = 0, nEv = 0;
    rstHold = 1;
    expect_st("pinRst", PMW_BOOT, 8);
    `CHK("noSave", 1'b0, saveReq)
    rstHold = 0;
    expect_st("pinRel", PMW_ACTIVE, 30);
    highLoad = 1;
    cyc(3);
    `CHK("buck", 1'b1, buckEn)
    linearOnly = 1;
    cyc(3);
    `CHK("ldoOnly", 1'b0, buckEn)
    `CHK("tag", 1'b1, nfcTagOnly)
    counterEn = 1;
    repeat (250) begin
      @(negedge core_clk);
      n += (rcCalStart === 1'b1);
      nEv += (counterEvent === 1'b1);
    end
    counterEn = 0;
    `CHK("rcCal", 1'b1, n >= 2)
    `CHK("lpcEvents", 11, nEv)
    brownOut = 1;
    expect_st("brown", PMW_OFF, 3);
    `CHK("brSave", 1'b0, saveReq)
    brownOut = 0;
    pwrOn = 0;
    cyc(6);
    pwrOn = 1;
    expect_st("reup", PMW_BOOT, 8);
    resetn = 0;
    cyc(2);
    `CHK("rstState", PMW_OFF, powerState)
    `CHK("rstSys", 1'b1, systemReset)
    resetn = 1;
    expect_st("rstBoot", PMW_BOOT, 8);
    $display("test reset done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #2_000_000;
    n_fail++;
    final_report();
  end
  initial begin
    cyc(5);
    resetn = 1;
    cyc(2);
    t_boot();
    t_softoff();
    for (int s = 0; s < 3; s++) t_standby(s);
    for (int s = 0; s < 3; s++) t_sleep(s);
    t_ctrl_dsr();
    t_reset_misc();
    final_report();
  end
endmodule
